// ===== logic/rbs_pkg.sv
// Package of constants and types for the reset and brown-out sequencer.
package rbs_pkg;
	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned PWRUP_DELAY_MS = 64;
	localparam int unsigned LFOSC_HZ = 31000;
	localparam int unsigned PWRUP_LF_TICKS = (LFOSC_HZ * PWRUP_DELAY_MS) / 1000;
	localparam int unsigned START_FOSC_CYCLES = 10;
	localparam int unsigned PIN_FILTER_CYCLES = 8;
	localparam logic [11:0] ADDR_BROWNOUT_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_REVISION_ID = 12'h004;
	localparam logic [11:0] ADDR_RESET_CAUSE = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00C;
	localparam int BC_SW_EN_BIT = 7;
	localparam int BC_FAST_START_BIT = 6;
	localparam int BC_READY_BIT = 0;
	localparam logic BC_SW_EN_RST = 1'b1;
	localparam logic BC_FAST_START_RST = 1'b0;
	localparam int RC_STACK_OVERFLOW_FLAG_BIT = 7;
	localparam int RC_STACK_UNDERFLOW_FLAG_BIT = 6;
	localparam int RC_WDT_BIT = 4;
	localparam int RC_PIN_BIT = 3;
	localparam int RC_RI_BIT = 2;
	localparam int RC_POR_BIT = 1;
	localparam int RC_BOR_BIT = 0;
	localparam logic [7:0] RC_WRITE_MASK = 8'hDF;
	localparam logic [7:0] RC_POR_VALUE = 8'h1C;
	localparam logic [1:0] BOR_MODE_ON = 2'h3;
	localparam logic [1:0] BOR_MODE_NOSLEEP = 2'h2;
	localparam logic [1:0] BOR_MODE_SW = 2'h1;
	localparam logic [1:0] BOR_MODE_OFF = 2'h0;
	localparam logic [13:0] REVISION_DEFAULT = 14'h2A5A;
	typedef enum logic [1:0] {RBS_POWERUP, RBS_WAIT, RBS_START, RBS_RUN} rbs_state_e;
endpackage

// ===== logic/rbs_sequencer.sv
// Reset and brown-out sequencer with an APB register slave.
`timescale 1ns/1ns
module rbs_sequencer #(
	parameter int unsigned PWRUP_TICKS = rbs_pkg::PWRUP_LF_TICKS,
	parameter logic [13:0] REVISION = rbs_pkg::REVISION_DEFAULT
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Configuration bits.
	input wire logic [1:0] brownout_mode_cfg,
	input wire logic powerup_delay_enable_n,
	input wire logic ext_reset_pin_enable,
	input wire logic lowvolt_program_enable,
	input wire logic lowpower_brownout_cfg,
	input wire logic stack_fault_reset_enable,
	// Supply monitors and power state.
	input wire logic por_active,
	input wire logic brownout_trip,
	input wire logic brownout_circuit_ready,
	input wire logic lowpower_brownout_trip,
	input wire logic program_mode_exit,
	input wire logic sleep_mode,
	input wire logic wake_request,
	input wire logic osc_ready,
	input wire logic lf_tick,
	// External reset pin.
	input wire logic ext_reset_pin_n,
	input wire logic pin_pullup_sw,
	// Core reset sources.
	input wire logic watchdog_timeout,
	input wire logic reset_instr,
	input wire logic stack_overflow,
	input wire logic stack_underflow,
	// Outputs.
	output logic core_reset_n,
	output logic brownout_enable,
	output logic bandgap_force_on,
	output logic lowpower_brownout_enable,
	output logic pin_reset_function,
	output logic pin_pullup_en,
	output logic pin_gpio_in,
	output logic wake_hold,
	output logic timeout_flag_n,
	output logic powerdown_flag_n
);
	import rbs_pkg::*;

	typedef struct packed {
		logic [1:0] por_sync;
		logic [1:0] bo_sync;
		logic [1:0] lbo_sync;
		logic [1:0] rdy_sync;
		logic [1:0] pin_sync;
		logic [1:0] tick_sync;
		logic [1:0] pgm_sync;
		logic tick_prev;
		logic pgm_prev;
		logic [3:0] filt_cnt;
		logic pin_low;
		logic [31:0] pwr_cnt;
		logic [3:0] start_cnt;
		rbs_state_e state;
		logic sw_en;
		logic fast_start;
		logic [7:0] cause;
		logic to_n;
		logic pd_n;
		logic rst_n;
		logic [31:0] rdata;
	} rbs_s;

	rbs_s s_q;
	rbs_s s_d;
	logic pin_en;
	logic bor_on;
	logic bor_req;
	logic wait_ready;
	logic power_event;
	logic soft_reset;
	logic pgm_exit;
	logic wr;
	logic rd;

	always_comb
	begin
		pin_en = lowvolt_program_enable | ext_reset_pin_enable;
		// Mode decode: always-on stays active asleep, no-sleep mode drops out; software mode uses the enable, asleep or not.
		case (brownout_mode_cfg)
			BOR_MODE_ON:
			begin
				bor_on = 1'b1;
			end
			BOR_MODE_NOSLEEP:
			begin
				bor_on = ~sleep_mode;
			end
			BOR_MODE_SW:
			begin
				bor_on = s_q.sw_en;
			end
			default:
			begin
				bor_on = 1'b0;
			end
		endcase
		wait_ready = (brownout_mode_cfg == BOR_MODE_ON) | (brownout_mode_cfg == BOR_MODE_NOSLEEP);
		// Software mode never waits for readiness, so a trip only counts once the circuit is ready.
		bor_req = (bor_on & s_q.bo_sync[1]
			& ((brownout_mode_cfg != BOR_MODE_SW) | s_q.rdy_sync[1]))
			| (lowpower_brownout_cfg & s_q.lbo_sync[1]);
		pgm_exit = s_q.pgm_sync[1] & ~s_q.pgm_prev;
		power_event = s_q.por_sync[1] | bor_req | pgm_exit;
		soft_reset = watchdog_timeout | reset_instr
			| (stack_fault_reset_enable & (stack_overflow | stack_underflow));
		wr = psel & penable & pwrite;
		rd = psel & ~penable & ~pwrite;
	end

	always_comb
	begin
		s_d = s_q;
		s_d.por_sync = {s_q.por_sync[0], por_active};
		s_d.bo_sync = {s_q.bo_sync[0], brownout_trip};
		s_d.lbo_sync = {s_q.lbo_sync[0], lowpower_brownout_trip};
		s_d.rdy_sync = {s_q.rdy_sync[0], brownout_circuit_ready};
		s_d.pin_sync = {s_q.pin_sync[0], ext_reset_pin_n};
		s_d.tick_sync = {s_q.tick_sync[0], lf_tick};
		s_d.pgm_sync = {s_q.pgm_sync[0], program_mode_exit};
		s_d.tick_prev = s_q.tick_sync[1];
		s_d.pgm_prev = s_q.pgm_sync[1];
		// A pin level must persist before it counts, so glitches never reset the core.
		if (s_q.pin_sync[1] == s_q.pin_low)
		begin
			s_d.filt_cnt = s_q.filt_cnt + 4'h1;
			if (s_q.filt_cnt == 4'(PIN_FILTER_CYCLES - 1))
			begin
				s_d.pin_low = ~s_q.pin_sync[1];
				s_d.filt_cnt = 4'h0;
			end
		end
		else
		begin
			s_d.filt_cnt = 4'h0;
		end
		case (s_q.state)
			RBS_POWERUP:
			begin
				s_d.rst_n = 1'b0;
				if (!power_event)
				begin
					if (powerup_delay_enable_n)
					begin
						s_d.state = RBS_WAIT;
					end
					else if (s_q.tick_sync[1] & ~s_q.tick_prev)
					begin
						s_d.pwr_cnt = s_q.pwr_cnt + 32'h1;
						if (s_q.pwr_cnt >= PWRUP_TICKS - 1)
						begin
							s_d.state = RBS_WAIT;
						end
					end
				end
			end
			RBS_WAIT:
			begin
				// Oscillator and brown-out waits run while the pin still holds reset.
				if (osc_ready && (!wait_ready || s_q.rdy_sync[1]))
				begin
					if (!(pin_en && s_q.pin_low))
					begin
						s_d.state = RBS_START;
						s_d.start_cnt = 4'h0;
					end
				end
			end
			RBS_START:
			begin
				s_d.start_cnt = s_q.start_cnt + 4'h1;
				if (s_q.start_cnt == 4'(START_FOSC_CYCLES - 1))
				begin
					s_d.state = RBS_RUN;
				end
				if (pin_en && s_q.pin_low)
				begin
					s_d.state = RBS_WAIT;
				end
			end
			RBS_RUN:
			begin
				s_d.rst_n = 1'b1;
				if (pin_en && s_q.pin_low)
				begin
					s_d.rst_n = 1'b0;
					s_d.state = RBS_WAIT;
					s_d.cause[RC_PIN_BIT] = 1'b0;
					s_d.pd_n = ~sleep_mode;
				end
				else if (soft_reset)
				begin
					s_d.rst_n = 1'b0;
					s_d.state = RBS_WAIT;
				end
			end
			default:
			begin
				s_d.state = RBS_POWERUP;
			end
		endcase
		if (s_q.state != RBS_RUN)
		begin
			s_d.rst_n = 1'b0;
		end
		if (wr)
		begin
			case (paddr)
				ADDR_BROWNOUT_CONTROL:
				begin
					s_d.sw_en = pwdata[BC_SW_EN_BIT];
					s_d.fast_start = pwdata[BC_FAST_START_BIT];
				end
				ADDR_RESET_CAUSE:
				begin
					s_d.cause = pwdata[7:0] & RC_WRITE_MASK;
				end
				default:
				begin
					// Writes to read-only or unmapped words are dropped without an error.
					s_d.sw_en = s_q.sw_en;
				end
			endcase
		end
		// Hardware events except the pin reset follow the software write, so a simultaneous one is kept.
		if (s_q.state == RBS_RUN && watchdog_timeout)
		begin
			s_d.cause[RC_WDT_BIT] = 1'b0;
			s_d.to_n = 1'b0;
			s_d.pd_n = ~sleep_mode;
		end
		if (s_q.state == RBS_RUN && reset_instr)
		begin
			s_d.cause[RC_RI_BIT] = 1'b0;
		end
		if (stack_fault_reset_enable && stack_overflow)
		begin
			s_d.cause[RC_STACK_OVERFLOW_FLAG_BIT] = 1'b1;
		end
		if (stack_fault_reset_enable && stack_underflow)
		begin
			s_d.cause[RC_STACK_UNDERFLOW_FLAG_BIT] = 1'b1;
		end
		if (bor_req)
		begin
			s_d.cause[RC_BOR_BIT] = 1'b0;
		end
		if (power_event)
		begin
			s_d.state = RBS_POWERUP;
			s_d.pwr_cnt = 32'h0;
			s_d.rst_n = 1'b0;
			s_d.to_n = 1'b1;
			s_d.pd_n = 1'b1;
		end
		if (s_q.por_sync[1] | pgm_exit)
		begin
			s_d.cause = RC_POR_VALUE;
			s_d.sw_en = BC_SW_EN_RST;
			s_d.fast_start = BC_FAST_START_RST;
		end
		s_d.rdata = 32'h0;
		if (rd)
		begin
			case (paddr)
				ADDR_BROWNOUT_CONTROL:
				begin
					s_d.rdata[BC_SW_EN_BIT] = s_q.sw_en;
					s_d.rdata[BC_FAST_START_BIT] = s_q.fast_start;
					s_d.rdata[BC_READY_BIT] = bor_on & s_q.rdy_sync[1];
				end
				ADDR_REVISION_ID:
				begin
					s_d.rdata[13:0] = REVISION;
				end
				ADDR_RESET_CAUSE:
				begin
					s_d.rdata[7:0] = s_q.cause;
				end
				ADDR_STATUS:
				begin
					s_d.rdata[3:0] = {s_q.to_n, s_q.pd_n, s_q.state};
				end
				default:
				begin
					// Unmapped words read as zero so software can probe safely.
					s_d.rdata = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
			s_q.pin_low <= 1'b0;
			s_q.state <= RBS_POWERUP;
			s_q.sw_en <= BC_SW_EN_RST;
			s_q.fast_start <= BC_FAST_START_RST;
			s_q.cause <= RC_POR_VALUE;
			s_q.to_n <= 1'b1;
			s_q.pd_n <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign core_reset_n = s_q.rst_n;
	assign brownout_enable = bor_on;
	assign bandgap_force_on = s_q.fast_start
		& ((brownout_mode_cfg == BOR_MODE_NOSLEEP) | (brownout_mode_cfg == BOR_MODE_SW));
	assign lowpower_brownout_enable = lowpower_brownout_cfg;
	assign pin_reset_function = pin_en;
	assign pin_pullup_en = pin_en ? 1'b1 : pin_pullup_sw;
	assign pin_gpio_in = s_q.pin_sync[1];
	assign wake_hold = wake_request & (brownout_mode_cfg == BOR_MODE_NOSLEEP)
		& ~s_q.rdy_sync[1];
	assign timeout_flag_n = s_q.to_n;
	assign powerdown_flag_n = s_q.pd_n;
endmodule

// ===== sim/rbs_monitor.sv
// Checker of the reset and brown-out sequencer ports.
`timescale 1ns/1ns
module rbs_monitor (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Inputs watched.
	input wire logic [1:0] brownout_mode_cfg,
	input wire logic ext_reset_pin_enable,
	input wire logic lowvolt_program_enable,
	input wire logic lowpower_brownout_cfg,
	input wire logic sleep_mode,
	input wire logic brownout_circuit_ready,
	input wire logic por_active,
	input wire logic ext_reset_pin_n,
	input wire logic pin_pullup_sw,
	input wire logic watchdog_timeout,
	// Outputs watched.
	input wire logic core_reset_n,
	input wire logic brownout_enable,
	input wire logic lowpower_brownout_enable,
	input wire logic pin_reset_function,
	input wire logic pin_pullup_en,
	input wire logic wake_hold,
	input wire logic timeout_flag_n
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_pin_low;
		(pin_reset_function && !ext_reset_pin_n) [*8];
	endsequence
	sequence s_start;
		$rose(core_reset_n) && brownout_mode_cfg == 2'h3;
	endsequence
	AST_PIN_FN: assert property (pin_reset_function ==
		(ext_reset_pin_enable || lowvolt_program_enable)) else $error("pin function wrong");
	AST_LPB: assert property (lowpower_brownout_enable == lowpower_brownout_cfg)
		else $error("low-power monitor gate wrong");
	AST_ON: assert property (brownout_mode_cfg == 2'h3 |-> brownout_enable)
		else $error("always-on mode not active");
	AST_OFF: assert property (brownout_mode_cfg == 2'h0 |-> !brownout_enable)
		else $error("off mode active");
	AST_SLEEP: assert property (brownout_mode_cfg == 2'h2 && sleep_mode |-> !brownout_enable)
		else $error("protection active in sleep");
	AST_WAKE: assert property (brownout_mode_cfg != 2'h2 |-> !wake_hold)
		else $error("wake delayed");
	AST_PIN: assert property (s_pin_low ##1 s_pin_low |-> !core_reset_n)
		else $error("low pin did not reset");
	AST_POR: assert property (por_active [*4] |-> !core_reset_n)
		else $error("core ran during power-on");
	AST_START: assert property (s_start |-> brownout_circuit_ready)
		else $error("start before brown-out ready");
	AST_WDT: assert property (watchdog_timeout |-> ##[1:3] !timeout_flag_n)
		else $error("time-out flag not cleared");
	AST_PULLUP: assert property (!pin_reset_function |-> pin_pullup_en == pin_pullup_sw)
		else $error("pull-up not under software");
endmodule
bind rbs_sequencer rbs_monitor i_rbs_monitor (.*);

// ===== sim/rbs_supply_model.sv
// Model of the reset pin and the supply monitors around the sequencer.
`timescale 1ns/1ns
module rbs_supply_model (
	// Requests from the bench.
	input wire logic pin_low_req,
	input wire logic por_req,
	input wire logic lowpower_brownout_req,
	// Pin and monitors.
	output logic ext_reset_pin_n,
	output logic por_active,
	output logic lowpower_brownout_trip,
	output logic brownout_circuit_ready,
	output logic lf_tick
);
	// The pin has a weak pull-up, so a released pin reads high.
	assign ext_reset_pin_n = pin_low_req ? 1'b0 : 1'b1;
	assign por_active = por_req;
	assign lowpower_brownout_trip = lowpower_brownout_req;
	assign brownout_circuit_ready = !por_req;
	// The slow oscillator runs free, out of phase with the bus clock.
	initial lf_tick = 1'b0;
	always #370 lf_tick = !lf_tick;
endmodule

// ===== sim/reset_and_brownout_sequencer_tb.sv
// Self-checking bench of the reset and brown-out sequencer.
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: %h not %h", $time, (g), (e)); end end
module reset_and_brownout_sequencer_tb;
	import rbs_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0] cause = 8'h1C;
	logic [1:0] brownout_mode_cfg = 2'h3;
	logic powerup_delay_enable_n = 1'b0, ext_reset_pin_enable = 1'b1;
	logic lowvolt_program_enable = 1'b0, lowpower_brownout_cfg = 1'b0;
	logic stack_fault_reset_enable = 1'b0, brownout_trip = 1'b0, program_mode_exit = 1'b0;
	logic sleep_mode = 1'b0, wake_request = 1'b0, osc_ready = 1'b1, pin_pullup_sw = 1'b0;
	logic watchdog_timeout = 1'b0, reset_instr = 1'b0, stack_overflow = 1'b0;
	logic stack_underflow = 1'b0, pin_low_req = 1'b0, por_req = 1'b1, lowpower_brownout_req = 1'b0;
	logic pready, pslverr, ext_reset_pin_n, por_active, lowpower_brownout_trip, sw, fs;
	logic brownout_circuit_ready, lf_tick, core_reset_n, brownout_enable, bandgap_force_on;
	logic lowpower_brownout_enable, pin_reset_function, pin_pullup_en, pin_gpio_in;
	logic wake_hold, timeout_flag_n, powerdown_flag_n;
	int n_fail = 0, n_checks = 0, seed = 98569, t, k;
	rbs_sequencer #(.PWRUP_TICKS(4)) i_rbs_sequencer (.*);
	rbs_supply_model i_rbs_supply_model (.*);
	always #50 pclk = !pclk;
	function automatic logic exp_bor(input logic [1:0] m, input logic s, input logic sl);
		return m == BOR_MODE_ON || (m == BOR_MODE_NOSLEEP && !sl) || (m == BOR_MODE_SW && s);
	endfunction
	task automatic end_of_test;
		if (n_fail == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20)
		begin
			n_fail++;
			end_of_test();
		end
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	task automatic wait_core(input logic v);
		for (t = 0; t < 3000 && core_reset_n !== v; t++)
			@(posedge pclk);
		`CHK(core_reset_n, v)
		if (t == 3000)
			end_of_test();
	endtask
	task automatic cycle_core;
		wait_core(1'b0);
		wait_core(1'b1);
	endtask
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		por_req <= 1'b0;
		wait_core(1'b1);
		`CHK(t > 30, 1'b1)
		rchk(ADDR_RESET_CAUSE, {24'h0, cause});
		rchk(ADDR_BROWNOUT_CONTROL, 32'h81);
		rchk(ADDR_REVISION_ID, {18'h0, REVISION_DEFAULT});
		rchk(12'h010, 32'h0);
		apb(1'b1, ADDR_RESET_CAUSE, 32'hFF);
		cause = 8'hDF;
		rchk(ADDR_RESET_CAUSE, {24'h0, cause});
		for (k = 0; k < 4; k++)
		begin
			sw = $random(seed);
			fs = $random(seed);
			brownout_mode_cfg <= k[1:0];
			pin_pullup_sw <= $random(seed);
			apb(1'b1, ADDR_BROWNOUT_CONTROL, {24'h0, sw, fs, 6'h3F});
			rchk(ADDR_BROWNOUT_CONTROL, {24'h0, sw, fs, 5'h0, exp_bor(k[1:0], sw, 1'b0)});
			`CHK(brownout_enable, exp_bor(k[1:0], sw, 1'b0))
			if (k == 1 || k == 2)
				`CHK(bandgap_force_on, fs)
		end
		brownout_mode_cfg <= BOR_MODE_NOSLEEP;
		sleep_mode <= 1'b1;
		repeat (2) @(posedge pclk);
		`CHK(brownout_enable, 1'b0)
		brownout_mode_cfg <= BOR_MODE_ON;
		repeat (2) @(posedge pclk);
		`CHK(brownout_enable, 1'b1)
		sleep_mode <= 1'b0;
		pin_low_req <= 1'b1;
		repeat (1 + $unsigned($random(seed)) % 5) @(posedge pclk);
		pin_low_req <= 1'b0;
		repeat (20) @(posedge pclk);
		`CHK(core_reset_n, 1'b1)
		ext_reset_pin_enable <= 1'b0;
		pin_low_req <= 1'b1;
		repeat (20) @(posedge pclk);
		`CHK(core_reset_n, 1'b1)
		`CHK(pin_gpio_in, 1'b0)
		lowvolt_program_enable <= 1'b1;
		wait_core(1'b0);
		repeat (60) @(posedge pclk);
		pin_low_req <= 1'b0;
		wait_core(1'b1);
		`CHK(t >= START_FOSC_CYCLES && t <= START_FOSC_CYCLES + PIN_FILTER_CYCLES + 6, 1'b1)
		cause[RC_PIN_BIT] = 1'b0;
		rchk(ADDR_RESET_CAUSE, {24'h0, cause});
		watchdog_timeout <= 1'b1;
		@(posedge pclk);
		watchdog_timeout <= 1'b0;
		cycle_core();
		`CHK(timeout_flag_n, 1'b0)
		`CHK(powerdown_flag_n, 1'b1)
		rchk(ADDR_STATUS, 32'h7);
		cause[RC_WDT_BIT] = 1'b0;
		rchk(ADDR_RESET_CAUSE, {24'h0, cause});
		reset_instr <= 1'b1;
		@(posedge pclk);
		reset_instr <= 1'b0;
		cycle_core();
		cause[RC_RI_BIT] = 1'b0;
		rchk(ADDR_RESET_CAUSE, {24'h0, cause});
		stack_overflow <= 1'b1;
		lowpower_brownout_req <= 1'b1;
		@(posedge pclk);
		stack_overflow <= 1'b0;
		repeat (20) @(posedge pclk);
		`CHK(core_reset_n, 1'b1)
		rchk(ADDR_RESET_CAUSE, {24'h0, cause});
		lowpower_brownout_req <= 1'b0;
		stack_fault_reset_enable <= 1'b1;
		stack_underflow <= 1'b1;
		@(posedge pclk);
		stack_underflow <= 1'b0;
		cycle_core();
		cause[RC_STACK_UNDERFLOW_FLAG_BIT] = 1'b1;
		rchk(ADDR_RESET_CAUSE, {24'h0, cause});
		lowpower_brownout_cfg <= 1'b1;
		lowpower_brownout_req <= 1'b1;
		wait_core(1'b0);
		lowpower_brownout_req <= 1'b0;
		wait_core(1'b1);
		cause[RC_BOR_BIT] = 1'b0;
		rchk(ADDR_RESET_CAUSE, {24'h0, cause});
		powerup_delay_enable_n <= 1'b1;
		program_mode_exit <= 1'b1;
		wait_core(1'b0);
		program_mode_exit <= 1'b0;
		wait_core(1'b1);
		`CHK(t < 30, 1'b1)
		rchk(ADDR_RESET_CAUSE, 32'h1C);
		apb(1'b1, ADDR_RESET_CAUSE, 32'hFF);
		brownout_mode_cfg <= BOR_MODE_NOSLEEP;
		wake_request <= 1'b1;
		por_req <= 1'b1;
		repeat (8) @(posedge pclk);
		`CHK(wake_hold, 1'b1)
		wake_request <= 1'b0;
		por_req <= 1'b0;
		wait_core(1'b1);
		rchk(ADDR_RESET_CAUSE, 32'h1C);
		end_of_test();
	end
endmodule
